//--- rtl/orrr_exec.sv
// execution slice: or-literal, or-into-memory, three returns, rotate-left of memory
// assumes one op strobe per cycle at most, memory read data valid with the strobe,
// and a stack that presents its top-of-stack word combinationally
`timescale 1ns/10ps
`include "orrr_defs.svh"
module orrr_exec (
	// clock and reset
	input  wire logic                  SYS_CLK,
	input  wire logic                  RST_N,
	// instruction
	input  wire logic                  OP_VALID,
	input  wire orrr_pkg::orrr_op_e    OP_CODE,
	input  wire logic [7:0]            OP_LITERAL,
	input  wire logic [7:0]            OP_ADDR,
	// data memory
	input  wire logic [7:0]            MEM_RDATA,
	output logic                       MEM_WE,
	output logic      [7:0]            MEM_ADDR,
	output logic      [7:0]            MEM_WDATA,
	// stack
	input  wire logic [`ORRR_PC_W-1:0] STACK_TOP,
	output logic                       STACK_POP,
	// interrupts
	input  wire logic                  IRQ_PENDING,
	input  wire logic                  MEIE_CLEAR,
	output logic                       IRQ_ENTER,
	output logic                       MASTER_IRQ_ENABLE,
	// state
	output logic      [7:0]            ACC,
	output logic                       ZERO_FLAG,
	output logic                       PC_LOAD,
	output logic      [`ORRR_PC_W-1:0] PC_VALUE
);
	// ==========================================================
	// decode
	function automatic logic is_ret(input orrr_pkg::orrr_op_e op);
		is_ret = (op == orrr_pkg::ORRR_OP_SUB_RET) || (op == orrr_pkg::ORRR_OP_RET_LIT) ||
			(op == orrr_pkg::ORRR_OP_IRQ_RET);
	endfunction : is_ret

	logic       go;
	logic       mem_op;
	logic       or_lit;
	logic [7:0] alu_b;
	logic [7:0] alu_res;
	logic       alu_zero;
	orrr_pkg::orrr_state_e st_q;
	orrr_pkg::orrr_state_e st_d;

	// no new op in the flush slot after an irq return or in the interrupt entry state
	assign go     = OP_VALID && (st_q == orrr_pkg::ORRR_ST_RUN);
	assign or_lit = go && (OP_CODE == orrr_pkg::ORRR_OP_OR_LIT);
	assign mem_op = go && ((OP_CODE == orrr_pkg::ORRR_OP_OR_MEM) || (OP_CODE == orrr_pkg::ORRR_OP_ROT_LEFT));
	assign alu_b  = (OP_CODE == orrr_pkg::ORRR_OP_OR_LIT) ? OP_LITERAL : MEM_RDATA;

	orrr_alu u_alu (
		.a_i    (ACC),
		.b_i    (alu_b),
		.rot_i  (OP_CODE == orrr_pkg::ORRR_OP_ROT_LEFT),
		.res_o  (alu_res),
		.zero_o (alu_zero)
	);

	// ==========================================================
	// working register and zero flag
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ACC <= `ORRR_ACC_RST;
		end else if (or_lit) begin
			ACC <= alu_res; // RL1
		end else if (go && OP_CODE == orrr_pkg::ORRR_OP_RET_LIT) begin
			ACC <= OP_LITERAL; // RL4
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ZERO_FLAG <= 1'b0;
		end else if (or_lit || (go && OP_CODE == orrr_pkg::ORRR_OP_OR_MEM)) begin
			ZERO_FLAG <= alu_zero; // RL1 RL2 RL9
		end
	end

	// ==========================================================
	// memory write-back
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			MEM_WE    <= 1'b0;
			MEM_ADDR  <= 8'h00;
			MEM_WDATA <= 8'h00;
		end else begin
			MEM_WE <= mem_op; // RL2 RL8
			if (mem_op) begin
				MEM_ADDR  <= OP_ADDR;
				MEM_WDATA <= alu_res; // RL2 RL8
			end
		end
	end

	// ==========================================================
	// returns and program counter
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			STACK_POP <= 1'b0;
			PC_LOAD   <= 1'b0;
			PC_VALUE  <= `ORRR_PC_RST;
		end else begin
			STACK_POP <= go && is_ret(OP_CODE); // RL3 RL4 RL5
			PC_LOAD   <= go && is_ret(OP_CODE);
			if (go && is_ret(OP_CODE)) begin
				PC_VALUE <= STACK_TOP; // RL3 RL4 RL5
			end
		end
	end

	// ==========================================================
	// master interrupt enable; the interrupt-return set beats the clear
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			MASTER_IRQ_ENABLE <= `ORRR_MEIE_RST;
		end else if (go && OP_CODE == orrr_pkg::ORRR_OP_IRQ_RET) begin
			MASTER_IRQ_ENABLE <= 1'b1; // RL5
		end else if (IRQ_ENTER || MEIE_CLEAR) begin
			MASTER_IRQ_ENABLE <= 1'b0;
		end
	end

	// ==========================================================
	// interrupt entry sequencing
	always_comb begin
		st_d = st_q;
		case (st_q)
			orrr_pkg::ORRR_ST_RUN: begin
				if (go && OP_CODE == orrr_pkg::ORRR_OP_IRQ_RET) begin
					st_d = orrr_pkg::ORRR_ST_FLUSH;
				end else if (IRQ_PENDING && MASTER_IRQ_ENABLE && !go) begin
					st_d = orrr_pkg::ORRR_ST_IRQ; // RL6
				end
			end
			orrr_pkg::ORRR_ST_FLUSH: begin
				// pending request taken before the main program resumes
				st_d = IRQ_PENDING ? orrr_pkg::ORRR_ST_IRQ : orrr_pkg::ORRR_ST_RUN; // RL7
			end
			orrr_pkg::ORRR_ST_IRQ: begin
				st_d = orrr_pkg::ORRR_ST_RUN;
			end
			default: begin
				st_d = orrr_pkg::ORRR_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q <= orrr_pkg::ORRR_ST_RUN;
		end else begin
			st_q <= st_d;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			IRQ_ENTER <= 1'b0;
		end else begin
			IRQ_ENTER <= (st_d == orrr_pkg::ORRR_ST_IRQ) && (st_q != orrr_pkg::ORRR_ST_IRQ); // RL6 RL7
		end
	end
endmodule : orrr_exec

//--- rtl/orrr_defs.svh
// constants for the or / return / rotate execution slice
// assumes an 8-bit data path, 13-bit program counter and a one-cycle decode strobe
//
// Functional notes
// RL1 - or-literal ors the working register with the literal, writes it back and updates the zero flag.
// RL2 - or_working_reg_into_memory ors the working register into the addressed byte, stores it there, updates zero.
// RL3 - subroutine_return pops the stack into the program counter and leaves every flag alone.
// RL4 - return_with_literal pops the program counter and loads the literal into the working register, no flags.
// RL5 - interrupt_return pops the program counter and sets master_irq_enable to one, no flags.
// RL6 - master_irq_enable gates every interrupt; while clear no interrupt routine is entered.
// RL7 - a request pending at interrupt_return is serviced before the main program resumes.
// RL8 - rotate_memory_left shifts the byte left one bit, old bit 7 into bit 0, stored in place, no flags.
// RL9 - an instruction that updates zero sets it for an all-zero 8-bit result and clears it otherwise.
`ifndef ORRR_DEFS_SVH
`define ORRR_DEFS_SVH

// ==========================================================
// widths and reset values
`define ORRR_DATA_W    8
`define ORRR_PC_W      13
`define ORRR_OP_W      3
`define ORRR_ACC_RST   8'h00
`define ORRR_PC_RST    13'h0000
`define ORRR_VEC_RST   13'h0004
`define ORRR_ZERO_BIT  0
`define ORRR_MEIE_RST  1'b0

`endif

//--- rtl/orrr_pkg.sv
// types for the or / return / rotate execution slice
// assumes orrr_defs.svh is on the include path
`include "orrr_defs.svh"
package orrr_pkg;
	// ==========================================================
	// operation selects
	typedef enum logic [`ORRR_OP_W-1:0] {
		ORRR_OP_NONE      = 3'h0,
		ORRR_OP_OR_LIT    = 3'h1,
		ORRR_OP_OR_MEM    = 3'h2,
		ORRR_OP_SUB_RET   = 3'h3,
		ORRR_OP_RET_LIT   = 3'h4,
		ORRR_OP_IRQ_RET   = 3'h5,
		ORRR_OP_ROT_LEFT  = 3'h6
	} orrr_op_e;

	typedef enum logic [2:0] {
		ORRR_ST_RUN   = 3'b001,
		ORRR_ST_FLUSH = 3'b010,
		ORRR_ST_IRQ   = 3'b100
	} orrr_state_e;
endpackage : orrr_pkg

//--- rtl/orrr_alu.sv
// byte logic unit: or and rotate-left with zero detect
// assumes purely combinational use inside the core clock domain
`timescale 1ns/10ps
module orrr_alu (
	// operands
	input  wire logic [7:0] a_i,
	input  wire logic [7:0] b_i,
	input  wire logic       rot_i,
	// results
	output logic      [7:0] res_o,
	output logic            zero_o
);
	// ==========================================================
	// datapath
	genvar g;
	logic [7:0] rot;
	generate
		for (g = 0; g < 7; g++) begin : g_rot
			assign rot[g+1] = b_i[g]; // RL8
		end
	endgenerate
	assign rot[0] = b_i[7]; // RL8
	assign res_o  = rot_i ? rot : (a_i | b_i); // RL1 RL2
	assign zero_o = (res_o == 8'h00); // RL9
endmodule : orrr_alu

//--- dv/orrr_exec_props.sv
// checker for the or / return / rotate execution slice
// assumes it is bound to orrr_exec and sees only that module's ports
`timescale 1ns/10ps
`include "orrr_defs.svh"
module orrr_exec_props (
	// clock and reset
	input wire logic                  SYS_CLK,
	input wire logic                  RST_N,
	// instruction
	input wire logic                  OP_VALID,
	input wire orrr_pkg::orrr_op_e    OP_CODE,
	input wire logic [7:0]            OP_LITERAL,
	input wire logic [7:0]            OP_ADDR,
	// memory and stack
	input wire logic [7:0]            MEM_RDATA,
	input wire logic                  MEM_WE,
	input wire logic [7:0]            MEM_ADDR,
	input wire logic [7:0]            MEM_WDATA,
	input wire logic [`ORRR_PC_W-1:0] STACK_TOP,
	input wire logic                  STACK_POP,
	// interrupts and state
	input wire logic                  IRQ_PENDING,
	input wire logic                  MEIE_CLEAR,
	input wire logic                  IRQ_ENTER,
	input wire logic                  MASTER_IRQ_ENABLE,
	input wire logic [7:0]            ACC,
	input wire logic                  ZERO_FLAG,
	input wire logic                  PC_LOAD,
	input wire logic [`ORRR_PC_W-1:0] PC_VALUE
);
	// ==========================================================
	// taken strobe: ops are ignored in the flush slot after an irq return and while entering
	// the entry pulse stands exactly while the sequencer sits in its entry state
	logic tk;
	logic ir1_q;
	assign tk = OP_VALID && !ir1_q && !IRQ_ENTER;
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ir1_q <= 1'b0;
		end else begin
			ir1_q <= tk && OP_CODE == orrr_pkg::ORRR_OP_IRQ_RET;
		end
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	a_or_lit_acc: assert property (tk && OP_CODE == orrr_pkg::ORRR_OP_OR_LIT |=>
		ACC == ($past(ACC) | $past(OP_LITERAL))) else $error("or literal result wrong");
	a_or_mem_write: assert property (tk && OP_CODE == orrr_pkg::ORRR_OP_OR_MEM |=> MEM_WE &&
		MEM_ADDR == $past(OP_ADDR) && MEM_WDATA == ($past(ACC) | $past(MEM_RDATA))) else $error("or memory wrong");
	a_zero_update: assert property (
		tk && OP_CODE inside {orrr_pkg::ORRR_OP_OR_LIT, orrr_pkg::ORRR_OP_OR_MEM} |=>
		ZERO_FLAG == (($past(ACC) | ($past(OP_CODE) == orrr_pkg::ORRR_OP_OR_LIT ?
		$past(OP_LITERAL) : $past(MEM_RDATA))) == 8'h00)) else $error("zero flag wrong");
	a_flags_kept: assert property (
		tk && OP_CODE inside {[orrr_pkg::ORRR_OP_SUB_RET:orrr_pkg::ORRR_OP_ROT_LEFT]} |=> $stable(ZERO_FLAG))
		else $error("flag changed");
	a_ret_pops_pc: assert property (
		tk && OP_CODE inside {[orrr_pkg::ORRR_OP_SUB_RET:orrr_pkg::ORRR_OP_IRQ_RET]} |=>
		STACK_POP && PC_LOAD && PC_VALUE == $past(STACK_TOP)) else $error("return pc wrong");
	a_ret_lit_acc: assert property (tk && OP_CODE == orrr_pkg::ORRR_OP_RET_LIT |=> ACC == $past(OP_LITERAL))
		else $error("return literal wrong");
	a_irq_ret_en: assert property (tk && OP_CODE == orrr_pkg::ORRR_OP_IRQ_RET |=> MASTER_IRQ_ENABLE)
		else $error("enable not set");
	a_irq_gated: assert property (IRQ_ENTER |-> $past(MASTER_IRQ_ENABLE)) else $error("entry while disabled");
	a_pend_served: assert property ((tk && OP_CODE == orrr_pkg::ORRR_OP_IRQ_RET) ##1
		(IRQ_PENDING && !MEIE_CLEAR && !OP_VALID) |=> IRQ_ENTER) else $error("pending not served");
	a_rot_left: assert property (tk && OP_CODE == orrr_pkg::ORRR_OP_ROT_LEFT |=> MEM_WE &&
		MEM_WDATA == {$past(MEM_RDATA[6:0]), $past(MEM_RDATA[7])}) else $error("rotate wrong");
endmodule : orrr_exec_props
bind orrr_exec orrr_exec_props i_props (.SYS_CLK, .RST_N, .OP_VALID, .OP_CODE, .OP_LITERAL, .OP_ADDR, .MEM_RDATA,
	.MEM_WE, .MEM_ADDR, .MEM_WDATA, .STACK_TOP, .STACK_POP, .IRQ_PENDING, .MEIE_CLEAR, .IRQ_ENTER,
	.MASTER_IRQ_ENABLE, .ACC, .ZERO_FLAG, .PC_LOAD, .PC_VALUE);

//--- dv/or_return_rotate_ops_bench.sv
// testbench for the or / return / rotate execution slice
// assumes inputs change on the falling edge and outputs settle one rising edge after an op
`timescale 1ns/10ps
`include "orrr_defs.svh"
module or_return_rotate_ops_bench;
	logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, pend = 1'b0, mclr = 1'b0;
	orrr_pkg::orrr_op_e code = orrr_pkg::ORRR_OP_NONE;
	logic [7:0] lit = 8'h00, addr = 8'h00, rdat = 8'h00;
	logic [`ORRR_PC_W-1:0] top = 13'h0000, pcv;
	logic we, pop, ent, mie, zf, pcl;
	logic [7:0] ma, mw, acc;
	int err_total = 0, total_checks = 0, cyc = 0;
	always #2.5 clk = ~clk;
	orrr_exec i_dut (.SYS_CLK(clk), .RST_N(rst_n), .OP_VALID(vld), .OP_CODE(code), .OP_LITERAL(lit),
		.OP_ADDR(addr), .MEM_RDATA(rdat), .MEM_WE(we), .MEM_ADDR(ma), .MEM_WDATA(mw), .STACK_TOP(top),
		.STACK_POP(pop), .IRQ_PENDING(pend), .MEIE_CLEAR(mclr), .IRQ_ENTER(ent), .MASTER_IRQ_ENABLE(mie),
		.ACC(acc), .ZERO_FLAG(zf), .PC_LOAD(pcl), .PC_VALUE(pcv));
	// ==========================================================
	// helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// strobe stays high between ops so back-to-back ops never toggle it twice
	task automatic op(input orrr_pkg::orrr_op_e c, input logic [7:0] l, input logic [7:0] d);
		code = c;
		lit = l;
		addr = l;
		rdat = d;
		vld = 1'b1;
		@(negedge clk);
	endtask : op
	task automatic results;
		$display("errors %0d checks %0d", err_total, total_checks);
		if (err_total == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : results
	// ==========================================================
	// scenarios
	task automatic t_data;
		op(orrr_pkg::ORRR_OP_OR_LIT, 8'h00, 8'h00);
		chk({7'h00, zf, acc}, 16'h0100);
		op(orrr_pkg::ORRR_OP_OR_LIT, 8'h81, 8'h00);
		chk({7'h00, zf, acc}, 16'h0081);
		op(orrr_pkg::ORRR_OP_OR_MEM, 8'h3c, 8'h42);
		chk({ma, mw}, 16'h3cc3);
		chk({we, zf, acc}, 16'h0281);
		top = 13'h0abc;
		op(orrr_pkg::ORRR_OP_RET_LIT, 8'h00, 8'h00);
		chk({pop, pcl, zf, acc}, 16'h0600);
		chk(pcv, 16'h0abc);
		op(orrr_pkg::ORRR_OP_OR_MEM, 8'h10, 8'h00);
		chk({we, zf, mw}, 16'h0300);
		op(orrr_pkg::ORRR_OP_ROT_LEFT, 8'h11, 8'h96);
		chk({we, zf, mw}, 16'h032d);
		op(orrr_pkg::ORRR_OP_ROT_LEFT, 8'h12, 8'h80);
		chk({we, zf, mw}, 16'h0301);
		chk(ma, 16'h0012);
		top = 13'h1555;
		op(orrr_pkg::ORRR_OP_SUB_RET, 8'hff, 8'h00);
		chk({pop, pcl, zf, acc}, 16'h0700);
		chk(pcv, 16'h1555);
		vld = 1'b0;
		@(negedge clk);
		chk({we, pop, pcl}, 16'h0000);
	endtask : t_data
	task automatic t_irq;
		pend = 1'b1;
		repeat (3) @(negedge clk);
		chk({mie, ent}, 16'h0000);
		top = 13'h0100;
		op(orrr_pkg::ORRR_OP_IRQ_RET, 8'h00, 8'h00);
		chk({mie, pcl, zf}, 16'h0007);
		chk(pcv, 16'h0100);
		vld = 1'b0;
		@(negedge clk);
		chk(ent, 16'h0001);
		pend = 1'b0;
		@(negedge clk);
		chk(mie, 16'h0000);
		op(orrr_pkg::ORRR_OP_IRQ_RET, 8'h00, 8'h00);
		chk(mie, 16'h0001);
		// an op strobed in the flush slot after an irq return is dropped
		op(orrr_pkg::ORRR_OP_OR_LIT, 8'hff, 8'h00);
		chk({zf, acc}, 16'h0100);
		vld = 1'b0;
		repeat (3) @(negedge clk);
		chk({mie, ent}, 16'h0002);
		mclr = 1'b1;
		@(negedge clk);
		mclr = 1'b0;
		pend = 1'b1;
		repeat (3) @(negedge clk);
		chk({mie, ent}, 16'h0000);
		pend = 1'b0;
	endtask : t_irq
	// ==========================================================
	// main sequence and hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			results();
		end
	end
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		t_data();
		t_irq();
		results();
	end
endmodule : or_return_rotate_ops_bench
